// ---- icl_pkg.sv ----
package icl_pkg;

  localparam int CLK_NS = 20;
  localparam int LINK_DIV = 8;
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [2:0] DIV_HALF = 3'h4;
  localparam int LINK_NS = CLK_NS * LINK_DIV;
  localparam int NBANK = 8;
  localparam int NTMR = 9;
  localparam int DEV_TMR = 8;

  // delays in ns, counted on link clock periods
  localparam int ACT_TO_ACT_DELAY_NS = 10;
  localparam int ACT_TO_COLUMN_DELAY_NS = 18;
  localparam int PRECHARGE_DELAY_NS = 18;
  localparam int MODE_READ_DELAY_NS = 40;
  localparam int MODE_WRITE_DELAY_NS = 80;
  localparam int POWER_DOWN_EXIT_DELAY_NS = 8;
  localparam int REFRESH_DELAY_NS = 210;
  localparam int INIT_DELAY_NS = 10000;

  // least times round up, never below one period
  function automatic logic [7:0] icl_ticks_up(input int ns);
    int t;
    t = (ns + LINK_NS - 1) / LINK_NS;
    if (t < 1) begin
      t = 1;
    end
    return t[7:0];
  endfunction

  localparam logic [7:0] RRD_TICKS = icl_ticks_up(ACT_TO_ACT_DELAY_NS);
  localparam logic [7:0] RCD_TICKS = icl_ticks_up(ACT_TO_COLUMN_DELAY_NS);
  localparam logic [7:0] RP_TICKS = icl_ticks_up(PRECHARGE_DELAY_NS);
  localparam logic [7:0] MRR_TICKS = icl_ticks_up(MODE_READ_DELAY_NS);
  localparam logic [7:0] MRW_TICKS = icl_ticks_up(MODE_WRITE_DELAY_NS);
  localparam logic [7:0] XP_TICKS = icl_ticks_up(POWER_DOWN_EXIT_DELAY_NS);
  localparam logic [7:0] RFC_TICKS = icl_ticks_up(REFRESH_DELAY_NS);
  localparam logic [7:0] INIT_TICKS = icl_ticks_up(INIT_DELAY_NS);
  // burst of eight beats, two per link period
  localparam logic [7:0] BURST_TICKS = 8'h04;
  localparam logic [2:0] BURST_CNT = 3'h4;
  localparam logic [2:0] RL_TICKS = 3'h3;
  localparam logic [15:0] MR_RESET_ADDR = 16'h003f;
  localparam logic [3:0] MASK_ALL = 4'hf;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD = 4'h2,
    CMD_WR = 4'h3,
    CMD_PRE = 4'h4,
    CMD_PREA = 4'h5,
    CMD_REF = 4'h6,
    CMD_MRW = 4'h7,
    CMD_MRR = 4'h8,
    CMD_RST = 4'h9
  } icl_cmd_t;

  typedef enum logic [3:0] {
    B_IDLE = 4'h0,
    B_ACTING = 4'h1,
    B_ACTIVE = 4'h2,
    B_PRE = 4'h3,
    B_RD = 4'h4,
    B_WR = 4'h5,
    B_RDAP = 4'h6,
    B_WRAP = 4'h7,
    B_MRR_I = 4'h8,
    B_MRR_A = 4'h9
  } icl_bank_t;

  typedef enum logic [2:0] {
    D_PWRON = 3'h0,
    D_RESETTING = 3'h1,
    D_NORMAL = 3'h2,
    D_MRW = 3'h3,
    D_MRR_RST = 3'h4,
    D_REFRESH = 3'h5
  } icl_dev_t;

  function automatic logic icl_is_rd(input icl_bank_t b);
    return (b == B_RD) || (b == B_RDAP);
  endfunction

  function automatic logic icl_is_wr(input icl_bank_t b);
    return (b == B_WR) || (b == B_WRAP);
  endfunction

  function automatic logic icl_is_mrr(input icl_bank_t b);
    return (b == B_MRR_I) || (b == B_MRR_A);
  endfunction

endpackage

// ---- icl_tmr_if.sv ----
`timescale 1ns/1ps
interface icl_tmr_if;
  logic start;
  logic [7:0] load;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output start, output load, output tick, input busy, input done);
  modport tmr (input start, input load, input tick, output busy, output done);
endinterface

// ---- icl_timer.sv ----
`timescale 1ns/1ps
module icl_timer (
  input wire logic clk,
  input wire logic rst_n,
  icl_tmr_if.tmr t
);

  typedef struct packed {
    logic [7:0] cnt;
  } icl_tmr_st_t;

  icl_tmr_st_t r;
  icl_tmr_st_t n;

  assign t.busy = (r.cnt != 8'h00);
  assign t.done = (r.cnt == 8'h01) && t.tick;

  // a fresh start overrides any count in flight
  always_comb begin
    n = r;
    if (t.start) begin
      n.cnt = t.load;
    end else if (t.tick && (r.cnt != 8'h00)) begin
      n.cnt = r.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

// ---- icl_host.sv ----
`timescale 1ns/1ps
// Functional notes
// - wait act_to_act_delay between activates
// - no write while any read burst
// - no read while any write burst
// - precharge all only when all valid
// - refresh and mode write need all idle
// - only nops during mode read/write
// - reset only at power-on, all idle (also taken in normal state when all banks are idle)
// - commands only after exit delay, cke high
// - refuse every unlisted command sequence
// - auto precharge frees its own bank
// - mask travels with each write beat
// - precharge of idle bank still waits
module icl_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire icl_pkg::icl_cmd_t req_cmd,
  input wire logic [2:0] req_bank,
  input wire logic req_ap,
  input wire logic [15:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_wmask,
  output logic req_ready,
  output logic req_err,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic dev_ck,
  output logic dev_cke,
  output logic dev_cs_n,
  output icl_pkg::icl_cmd_t dev_cmd,
  output logic [2:0] dev_bank,
  output logic dev_ap,
  output logic [15:0] dev_addr,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic dq_oe,
  output logic [3:0] write_byte_mask
);

  typedef struct packed {
    logic [2:0] div;
    logic ck;
    logic cke;
    logic started;
    icl_pkg::icl_dev_t dst;
    icl_pkg::icl_bank_t [icl_pkg::NBANK-1:0] bst;
    logic [7:0] rrd;
    logic [icl_pkg::RL_TICKS-1:0] rdp;
    logic [2:0] wrc;
    logic cs_n;
    icl_pkg::icl_cmd_t cmd;
    logic [2:0] bank;
    logic ap;
    logic [15:0] addr;
    logic [31:0] dq_out;
    logic dq_oe;
    logic [3:0] mask;
    logic [31:0] rd_data;
    logic rd_valid;
    logic [31:0] dq_s1;
    logic [31:0] dq_s2;
  } icl_host_st_t;

  icl_host_st_t r;
  icl_host_st_t n;
  logic tick;
  logic legal;
  logic [icl_pkg::NTMR-1:0] tstart;
  logic [icl_pkg::NTMR-1:0][7:0] tload;
  logic [icl_pkg::NTMR-1:0] tbusy;
  logic [icl_pkg::NTMR-1:0] tdone;

  icl_tmr_if tmr[icl_pkg::NTMR] ();

  // one timer per bank plus one for device-wide waits
  for (genvar g = 0; g < icl_pkg::NTMR; g++) begin : g_tmr
    assign tmr[g].start = tstart[g];
    assign tmr[g].load = tload[g];
    assign tmr[g].tick = tick;
    assign tbusy[g] = tmr[g].busy;
    assign tdone[g] = tmr[g].done;
    icl_timer u_tmr (
      .clk(clk),
      .rst_n(rst_n),
      .t(tmr[g])
    );
  end

  // commands change on the falling link edge, device samples the rising one
  assign tick = (r.div == icl_pkg::DIV_LAST);

  assign dev_ck = r.ck;
  assign dev_cke = r.cke;
  assign dev_cs_n = r.cs_n;
  assign dev_cmd = r.cmd;
  assign dev_bank = r.bank;
  assign dev_ap = r.ap;
  assign dev_addr = r.addr;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
  assign write_byte_mask = r.mask;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
  assign req_ready = req_valid && tick && legal;
  assign req_err = req_valid && tick && !legal;

  always_comb begin
    icl_pkg::icl_bank_t tb;
    logic any_rd;
    logic any_wr;
    logic any_mrr;
    logic any_burst;
    logic all_idle;
    logic all_pre_ok;
    logic quiet;
    tb = r.bst[req_bank];
    any_burst = 1'b0;
    quiet = 1'b0;
    any_rd = 1'b0;
    any_wr = 1'b0;
    any_mrr = 1'b0;
    all_idle = 1'b1;
    all_pre_ok = 1'b1;
    for (int b = 0; b < icl_pkg::NBANK; b++) begin
      any_rd = any_rd | icl_pkg::icl_is_rd(r.bst[b]);
      any_wr = any_wr | icl_pkg::icl_is_wr(r.bst[b]);
      any_mrr = any_mrr | icl_pkg::icl_is_mrr(r.bst[b]);
      all_idle = all_idle & (r.bst[b] == icl_pkg::B_IDLE);
      all_pre_ok = all_pre_ok & ((r.bst[b] == icl_pkg::B_IDLE) || (r.bst[b] == icl_pkg::B_ACTIVE));
    end
    any_burst = any_rd | any_wr;
    quiet = (r.dst == icl_pkg::D_NORMAL) && !any_mrr;

    // anything not matched below is refused
    legal = 1'b0;
    case (req_cmd)
      icl_pkg::CMD_NOP: legal = 1'b1;
      icl_pkg::CMD_ACT: legal = quiet && (tb == icl_pkg::B_IDLE) && (r.rrd == 8'h00);
      icl_pkg::CMD_RD: legal = quiet && ((tb == icl_pkg::B_ACTIVE) || (tb == icl_pkg::B_RD)) && !any_wr;
      icl_pkg::CMD_WR: legal = quiet && ((tb == icl_pkg::B_ACTIVE) || (tb == icl_pkg::B_WR)) && !any_rd;
      icl_pkg::CMD_PRE: legal = quiet && ((tb == icl_pkg::B_IDLE) || (tb == icl_pkg::B_ACTIVE));
      icl_pkg::CMD_PREA: legal = quiet && all_pre_ok;
      icl_pkg::CMD_REF: legal = quiet && all_idle;
      icl_pkg::CMD_MRW: legal = quiet && all_idle;
      icl_pkg::CMD_MRR: legal = (quiet && !any_burst
                                 && (tb inside {icl_pkg::B_IDLE, icl_pkg::B_ACTING, icl_pkg::B_ACTIVE, icl_pkg::B_PRE}))
                                || (r.dst == icl_pkg::D_RESETTING);
      icl_pkg::CMD_RST: legal = ((r.dst == icl_pkg::D_PWRON) && r.started && !tbusy[icl_pkg::DEV_TMR])
                                || (quiet && all_idle && !any_burst);
      default: legal = 1'b0;
    endcase

    n = r;
    tstart = '0;
    tload = '0;
    n.div = r.div + 3'h1;
    n.ck = (n.div >= icl_pkg::DIV_HALF);
    n.cke = 1'b1;
    n.rd_valid = 1'b0;
    n.dq_s1 = dq_in;
    n.dq_s2 = r.dq_s1;

    // cke is high from here on; hold off all commands for the exit delay
    if ((r.dst == icl_pkg::D_PWRON) && !r.started) begin
      n.started = 1'b1;
      tstart[icl_pkg::DEV_TMR] = 1'b1;
      tload[icl_pkg::DEV_TMR] = icl_pkg::XP_TICKS;
    end

    // timed state ends
    for (int b = 0; b < icl_pkg::NBANK; b++) begin
      if (tdone[b]) begin
        case (r.bst[b])
          icl_pkg::B_ACTING: n.bst[b] = icl_pkg::B_ACTIVE;
          icl_pkg::B_PRE: n.bst[b] = icl_pkg::B_IDLE;
          icl_pkg::B_RD: n.bst[b] = icl_pkg::B_ACTIVE;
          icl_pkg::B_WR: n.bst[b] = icl_pkg::B_ACTIVE;
          icl_pkg::B_RDAP: n.bst[b] = icl_pkg::B_IDLE;
          icl_pkg::B_WRAP: n.bst[b] = icl_pkg::B_IDLE;
          icl_pkg::B_MRR_I: n.bst[b] = icl_pkg::B_IDLE;
          icl_pkg::B_MRR_A: n.bst[b] = icl_pkg::B_ACTIVE;
          default: n.bst[b] = r.bst[b];
        endcase
      end
    end
    if (tdone[icl_pkg::DEV_TMR]) begin
      case (r.dst)
        icl_pkg::D_RESETTING: n.dst = icl_pkg::D_NORMAL;
        icl_pkg::D_MRW: n.dst = icl_pkg::D_NORMAL;
        icl_pkg::D_REFRESH: n.dst = icl_pkg::D_NORMAL;
        icl_pkg::D_MRR_RST: begin
          // back to the reset state, initialisation runs its full time again
          n.dst = icl_pkg::D_RESETTING;
          tstart[icl_pkg::DEV_TMR] = 1'b1;
          tload[icl_pkg::DEV_TMR] = icl_pkg::INIT_TICKS;
        end
        default: n.dst = r.dst;
      endcase
    end

    if (tick) begin
      n.cs_n = 1'b1;
      n.cmd = icl_pkg::CMD_NOP;
      n.ap = 1'b0;
      if (r.rrd != 8'h00) begin
        n.rrd = r.rrd - 8'h01;
      end
      // one stage per pending read, so back-to-back reads each return their word
      n.rdp = {r.rdp[icl_pkg::RL_TICKS-2:0], 1'b0};
      if (r.rdp[icl_pkg::RL_TICKS-1]) begin
        n.rd_data = r.dq_s2;
        n.rd_valid = 1'b1;
      end
      if (r.wrc != 3'h0) begin
        n.wrc = r.wrc - 3'h1;
      end
      n.dq_oe = (n.wrc != 3'h0);
      if (n.wrc == 3'h0) begin
        n.mask = icl_pkg::MASK_ALL;
      end
    end

    if (req_valid && tick && legal && (req_cmd != icl_pkg::CMD_NOP)) begin
      n.cs_n = 1'b0;
      n.cmd = req_cmd;
      n.bank = req_bank;
      n.addr = req_addr;
      n.ap = req_ap && ((req_cmd == icl_pkg::CMD_RD) || (req_cmd == icl_pkg::CMD_WR));
      case (req_cmd)
        icl_pkg::CMD_ACT: begin
          n.bst[req_bank] = icl_pkg::B_ACTING;
          tstart[req_bank] = 1'b1;
          tload[req_bank] = icl_pkg::RCD_TICKS;
          // counts only the periods still barred, the issuing one excluded
          n.rrd = icl_pkg::RRD_TICKS - 8'h01;
        end
        icl_pkg::CMD_RD: begin
          n.bst[req_bank] = req_ap ? icl_pkg::B_RDAP : icl_pkg::B_RD;
          tstart[req_bank] = 1'b1;
          tload[req_bank] = req_ap ? icl_pkg::BURST_TICKS + icl_pkg::RP_TICKS : icl_pkg::BURST_TICKS;
          n.rdp[0] = 1'b1;
        end
        icl_pkg::CMD_WR: begin
          n.bst[req_bank] = req_ap ? icl_pkg::B_WRAP : icl_pkg::B_WR;
          tstart[req_bank] = 1'b1;
          tload[req_bank] = req_ap ? icl_pkg::BURST_TICKS + icl_pkg::RP_TICKS : icl_pkg::BURST_TICKS;
          n.wrc = icl_pkg::BURST_CNT;
          n.dq_out = req_wdata;
          n.mask = req_wmask;
          n.dq_oe = 1'b1;
        end
        icl_pkg::CMD_PRE: begin
          // an idle bank still serves the full precharge wait
          n.bst[req_bank] = icl_pkg::B_PRE;
          tstart[req_bank] = 1'b1;
          tload[req_bank] = icl_pkg::RP_TICKS;
        end
        icl_pkg::CMD_PREA: begin
          for (int b = 0; b < icl_pkg::NBANK; b++) begin
            n.bst[b] = icl_pkg::B_PRE;
            tstart[b] = 1'b1;
            tload[b] = icl_pkg::RP_TICKS;
          end
        end
        icl_pkg::CMD_REF: begin
          n.dst = icl_pkg::D_REFRESH;
          tstart[icl_pkg::DEV_TMR] = 1'b1;
          tload[icl_pkg::DEV_TMR] = icl_pkg::RFC_TICKS;
        end
        icl_pkg::CMD_MRW: begin
          n.dst = icl_pkg::D_MRW;
          tstart[icl_pkg::DEV_TMR] = 1'b1;
          tload[icl_pkg::DEV_TMR] = icl_pkg::MRW_TICKS;
        end
        icl_pkg::CMD_MRR: begin
          if (r.dst == icl_pkg::D_RESETTING) begin
            n.dst = icl_pkg::D_MRR_RST;
            tstart[icl_pkg::DEV_TMR] = 1'b1;
            tload[icl_pkg::DEV_TMR] = icl_pkg::MRR_TICKS;
          end else begin
            n.bst[req_bank] = ((tb == icl_pkg::B_IDLE) || (tb == icl_pkg::B_PRE)) ?
                              icl_pkg::B_MRR_I : icl_pkg::B_MRR_A;
            tstart[req_bank] = 1'b1;
            tload[req_bank] = icl_pkg::MRR_TICKS;
          end
        end
        icl_pkg::CMD_RST: begin
          n.cmd = icl_pkg::CMD_MRW;
          n.addr = icl_pkg::MR_RESET_ADDR;
          n.dst = icl_pkg::D_RESETTING;
          for (int b = 0; b < icl_pkg::NBANK; b++) begin
            n.bst[b] = icl_pkg::B_IDLE;
          end
          tstart[icl_pkg::DEV_TMR] = 1'b1;
          tload[icl_pkg::DEV_TMR] = icl_pkg::INIT_TICKS;
        end
        default: n.cmd = icl_pkg::CMD_NOP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.mask <= 4'hf;
    end else begin
      r <= n;
    end
  end

endmodule

// ---- icl_host_chk.sv ----
`timescale 1ns/1ps
module icl_host_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire icl_pkg::icl_cmd_t req_cmd,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_wmask,
  input wire logic req_ready,
  input wire logic req_err,
  input wire logic rd_valid,
  input wire logic dev_ck,
  input wire logic dev_cke,
  input wire logic dev_cs_n,
  input wire icl_pkg::icl_cmd_t dev_cmd,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe,
  input wire logic [3:0] write_byte_mask
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic rd_go;
  logic wr_go;
  assign rd_go = req_ready && req_cmd == icl_pkg::CMD_RD;
  assign wr_go = req_ready && req_cmd == icl_pkg::CMD_WR;

  // reset must be checked while it is asserted, so no disable here
  AST_RESET_PINS: assert property (disable iff (1'b0) !rst_n |=> dev_cs_n && !dev_cke && !dq_oe)
    else $error("pins not quiet after reset edge");
  AST_CKE_UP: assert property ($past(rst_n) |-> dev_cke)
    else $error("clock enable low outside reset");
  AST_ONE_PER_PERIOD: assert property ((req_ready || req_err) |=> !(req_ready || req_err) [*7])
    else $error("two answers within one link period");
  AST_CMD_OUT: assert property (req_ready && req_cmd != icl_pkg::CMD_NOP |=> !dev_cs_n
    && dev_cmd == ($past(req_cmd) == icl_pkg::CMD_RST ? icl_pkg::CMD_MRW : $past(req_cmd)))
    else $error("taken command not driven on pins");
  AST_NO_RST_CODE: assert property (!dev_cs_n |-> dev_cmd != icl_pkg::CMD_RST)
    else $error("reset code seen on command pins");
  AST_ERR_QUIET: assert property (req_err |=> dev_cs_n)
    else $error("refused command reached the pins");
  AST_MASK_IDLE: assert property (!dq_oe |-> write_byte_mask == icl_pkg::MASK_ALL)
    else $error("mask not inhibiting while bus undriven");
  AST_WR_BEAT: assert property (wr_go |=> dq_oe && dq_out == $past(req_wdata)
    && write_byte_mask == $past(req_wmask))
    else $error("write data or mask not with command");
  AST_WR_LEN: assert property ($rose(dq_oe) |-> ##31 dq_oe ##1 !dq_oe)
    else $error("write burst length wrong");
  AST_NO_WR_IN_RD: assert property (rd_go |=> !wr_go [*8])
    else $error("write taken during read burst");
  AST_NO_RD_IN_WR: assert property (wr_go |=> !rd_go [*8])
    else $error("read taken during write burst");
  AST_RD_DATA: assert property (rd_go |-> ##[23:25] rd_valid)
    else $error("read word not returned in time");
  AST_CK_SHAPE: assert property ($rose(dev_ck) |=> dev_ck [*3] ##1 !dev_ck [*4] ##1 dev_ck)
    else $error("link clock not clk over eight");
  AST_CMD_STEADY: assert property ($rose(dev_ck) |-> $stable(dev_cs_n) && $stable(dev_cmd))
    else $error("command changed at link clock rise");
endmodule

bind icl_host icl_host_chk i_chk (.*);

// ---- icl_dev_model.sv ----
`timescale 1ns/1ps
module icl_dev_model (
  input wire logic clk,
  input wire logic dev_ck,
  input wire logic dev_cke,
  input wire logic dev_cs_n,
  input wire icl_pkg::icl_cmd_t dev_cmd,
  input wire logic [2:0] dev_bank,
  input wire logic dev_ap,
  input wire logic [15:0] dev_addr,
  output logic [31:0] dq_in
);
  icl_pkg::icl_bank_t st [8];
  logic [1:0] rd_cnt [8];
  logic cke_q = 1'b0;
  logic [31:0] drift = 32'h0;
  int i;
  int j;
  initial begin
    for (i = 0; i < 8; i++) begin
      st[i] = icl_pkg::B_IDLE;
      rd_cnt[i] = 2'h0;
    end
  end
  // a released data bus never holds its last word
  always @(posedge clk) drift <= drift + 32'h1357_9bdf;
  always @* begin
    dq_in = drift;
    for (j = 0; j < 8; j++) begin
      if (rd_cnt[j] == 2'h1) begin
        dq_in = {16'ha5a5, 13'h0, 3'(j)};
      end
    end
  end
  always @(posedge dev_ck) begin
    cke_q <= dev_cke;
    for (i = 0; i < 8; i++) begin
      if (rd_cnt[i] != 2'h0) begin
        rd_cnt[i] <= rd_cnt[i] - 2'h1;
      end
      case (st[i])
        icl_pkg::B_PRE: st[i] <= icl_pkg::B_IDLE;
        icl_pkg::B_MRR_I: st[i] <= icl_pkg::B_IDLE;
        icl_pkg::B_MRR_A: st[i] <= icl_pkg::B_ACTIVE;
        default: ;
      endcase
    end
    if (dev_cke && cke_q && !dev_cs_n) begin
      case (dev_cmd)
        icl_pkg::CMD_ACT: st[dev_bank] <= icl_pkg::B_ACTIVE;
        icl_pkg::CMD_RD: begin
          st[dev_bank] <= dev_ap ? icl_pkg::B_RDAP : icl_pkg::B_RD;
          rd_cnt[dev_bank] <= 2'h3;
        end
        icl_pkg::CMD_WR: st[dev_bank] <= dev_ap ? icl_pkg::B_WRAP : icl_pkg::B_WR;
        icl_pkg::CMD_PRE: st[dev_bank] <= icl_pkg::B_PRE;
        icl_pkg::CMD_PREA: begin
          for (i = 0; i < 8; i++) st[i] <= icl_pkg::B_PRE;
        end
        icl_pkg::CMD_MRR: begin
          st[dev_bank] <= (st[dev_bank] == icl_pkg::B_ACTIVE) ? icl_pkg::B_MRR_A : icl_pkg::B_MRR_I;
        end
        icl_pkg::CMD_MRW: begin
          if (dev_addr == icl_pkg::MR_RESET_ADDR) begin
            for (i = 0; i < 8; i++) st[i] <= icl_pkg::B_IDLE;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    int gap;
    icl_pkg::icl_cmd_t c;
    logic [2:0] b;
    logic ap;
    logic [3:0] m;
    logic e;
  } icl_row_t;
  logic clk, rst_n, req_valid, req_ap, req_ready, req_err, rd_valid;
  logic dev_ck, dev_cke, dev_cs_n, dev_ap, dq_oe;
  icl_pkg::icl_cmd_t req_cmd, dev_cmd;
  logic [2:0] req_bank, dev_bank;
  logic [15:0] req_addr, dev_addr;
  logic [31:0] req_wdata, rd_data, dq_in, dq_out;
  logic [3:0] req_wmask, write_byte_mask;
  logic [31:0] rd_q [$];
  icl_row_t rows [17];
  int n_errors = 0;
  int samples_checked = 0;
  logic e;
  int r;

  icl_host i_dut (.*);
  icl_dev_model i_dev (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // called at a falling edge; returns with valid released
  task automatic issue(input icl_pkg::icl_cmd_t c, input logic [2:0] b, input logic ap,
                       input logic [31:0] d, input logic [3:0] m, output logic err);
    int k;
    logic [24:0] pin_exp;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_ap = ap;
    req_wdata = d;
    req_wmask = m;
    for (k = 0; k < 16 && req_ready !== 1'b1 && req_err !== 1'b1; k++) @(negedge clk);
    // a lost answer counts once and the run carries on to the verdict
    if (k == 16) begin
      n_errors++;
    end
    err = req_err;
    @(negedge clk);
    req_valid = 1'b0;
    pin_exp = {1'b0, c, b, ap && (c == icl_pkg::CMD_RD || c == icl_pkg::CMD_WR), req_addr};
    if (c == icl_pkg::CMD_RST) pin_exp = {1'b0, icl_pkg::CMD_MRW, b, 1'b0, icl_pkg::MR_RESET_ADDR};
    if (!err && c == icl_pkg::CMD_NOP) chk({dev_cs_n, dev_cmd}, {1'b1, icl_pkg::CMD_NOP});
    if (!err && c != icl_pkg::CMD_NOP) chk({dev_cs_n, dev_cmd, dev_bank, dev_ap, dev_addr}, pin_exp);
    if (c == icl_pkg::CMD_RD && !err) rd_q.push_back({16'ha5a5, 13'h0, b});
    if (c == icl_pkg::CMD_WR && !err) chk({dq_oe, write_byte_mask, dq_out}, {1'b1, m, d});
    @(negedge clk);
  endtask

  always @(negedge clk) if (rd_valid === 1'b1) chk(rd_data, rd_q.pop_front());

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = icl_pkg::CMD_NOP;
    req_bank = 3'h0;
    req_ap = 1'b0;
    req_addr = 16'h0010;
    req_wdata = 32'h0;
    req_wmask = 4'h0;
    rows = '{'{0, icl_pkg::CMD_ACT, 3'h0, 1'b0, 4'h0, 1'b0},
             '{0, icl_pkg::CMD_ACT, 3'h1, 1'b0, 4'h0, 1'b0},
             '{2, icl_pkg::CMD_RD, 3'h0, 1'b0, 4'h0, 1'b0},
             '{0, icl_pkg::CMD_WR, 3'h1, 1'b0, 4'h0, 1'b1},
             '{0, icl_pkg::CMD_RD, 3'h1, 1'b1, 4'h0, 1'b0},
             '{6, icl_pkg::CMD_WR, 3'h0, 1'b0, 4'h5, 1'b0},
             '{0, icl_pkg::CMD_RD, 3'h0, 1'b0, 4'h0, 1'b1},
             '{6, icl_pkg::CMD_MRR, 3'h0, 1'b0, 4'h0, 1'b0},
             '{0, icl_pkg::CMD_ACT, 3'h2, 1'b0, 4'h0, 1'b1},
             '{2, icl_pkg::CMD_PRE, 3'h0, 1'b0, 4'h0, 1'b0},
             '{0, icl_pkg::CMD_MRW, 3'h3, 1'b0, 4'h0, 1'b1},
             '{2, icl_pkg::CMD_PREA, 3'h0, 1'b0, 4'h0, 1'b0},
             '{2, icl_pkg::CMD_REF, 3'h0, 1'b0, 4'h0, 1'b0},
             '{3, icl_pkg::CMD_MRW, 3'h0, 1'b0, 4'h0, 1'b0},
             '{2, icl_pkg::CMD_ACT, 3'h4, 1'b0, 4'h0, 1'b0},
             '{0, icl_pkg::CMD_MRR, 3'h5, 1'b0, 4'h0, 1'b0},
             '{2, icl_pkg::CMD_RST, 3'h0, 1'b0, 4'h0, 1'b1}};
    repeat (8) @(negedge clk);
    chk({dev_cs_n, dev_cke, dq_oe, write_byte_mask}, {1'b1, 1'b0, 1'b0, 4'hf});
    rst_n = 1'b1;
    repeat (24) @(negedge clk);
    issue(icl_pkg::CMD_RST, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b0);
    issue(icl_pkg::CMD_ACT, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b1);
    issue(icl_pkg::CMD_MRR, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b0);
    // mode read in resetting reruns the whole init count
    repeat (600) @(negedge clk);
    for (r = 0; r < 17; r++) begin
      repeat (8 * rows[r].gap) @(negedge clk);
      issue(rows[r].c, rows[r].b, rows[r].ap, 32'h1234_5600 + 32'(r), rows[r].m, e);
      chk(e, rows[r].e);
    end
    repeat (80) @(negedge clk);
    chk(rd_q.size(), 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({dev_cs_n, dev_cke}, {1'b1, 1'b0});
    rst_n = 1'b1;
    repeat (24) @(negedge clk);
    issue(icl_pkg::CMD_ACT, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b1);
    issue(icl_pkg::CMD_NOP, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b0);
    issue(icl_pkg::CMD_RST, 3'h0, 1'b0, 32'h0, 4'h0, e);
    chk(e, 1'b0);
    results();
  end
endmodule
